//--- logic/fault_report_pkg.sv
`default_nettype none

package fault_report_pkg;
    // Byte counts of the two unit variants
    localparam int LARGE_IN_BYTES = 12;
    localparam int LARGE_OUT_BYTES = 8;
    localparam int SMALL_IN_BYTES = 8;
    localparam int SMALL_OUT_BYTES = 4;
    localparam int MAX_OUT_BYTES = 8;
    localparam int MAX_IN_BYTES = 12;
    // Widths of the link address and of the report fields
    localparam int ADDR_W = 16;
    localparam int GROUP_W = 5;
    localparam int PATH_W = 4;
    localparam int SLOT_W = 4;
    localparam int INFO_W = 3;
    localparam int TYPE_W = 4;
    // Fixed field values of a status-alarm entry
    localparam logic [TYPE_W-1:0] ALARM_TYPE = 4'h0;
    localparam logic [SLOT_W-1:0] ALARM_SLOT = 4'h1;
    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [MAX_OUT_BYTES-1:0] PEND_RESET = 8'h00;

    // One status-alarm entry for the controller's system relay area
    typedef struct packed {
        logic [TYPE_W-1:0] kind;
        logic [GROUP_W-1:0] group;
        logic [PATH_W-1:0] path;
        logic [SLOT_W-1:0] slot;
        logic [INFO_W-1:0] info;
        logic [ADDR_W-1:0] out_addr;
        logic [7:0] data;
    } alarm_entry_t;

    // Output byte write from the link
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } out_write_t;
endpackage

`default_nettype wire

//--- logic/output_fault_status_reporting.sv
`timescale 1ns/100ps
`default_nettype none

module output_fault_status_reporting #(
    parameter bit LARGE_UNIT = 1'b1
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [fault_report_pkg::ADDR_W-1:0] input_area_base_i,
    input wire logic [fault_report_pkg::ADDR_W-1:0] output_area_base_i,
    input wire logic [fault_report_pkg::GROUP_W-1:0] group_i,
    input wire logic [fault_report_pkg::PATH_W-1:0] path_i,
    input wire logic [fault_report_pkg::MAX_IN_BYTES*8-1:0] in_points_i,
    input wire logic [fault_report_pkg::ADDR_W-1:0] in_rd_addr_i,
    output logic [7:0] in_rd_data_o,
    output logic in_rd_hit_o,
    input wire fault_report_pkg::out_write_t out_wr_i,
    output logic out_wr_hit_o,
    input wire logic [fault_report_pkg::MAX_OUT_BYTES-1:0] byte_trip_i,
    input wire logic [fault_report_pkg::MAX_OUT_BYTES*8-1:0] point_fault_i,
    output logic [fault_report_pkg::MAX_OUT_BYTES*8-1:0] out_points_o,
    output logic unit_alarm_o,
    output logic alarm_valid_o,
    input wire logic alarm_ready_i,
    output fault_report_pkg::alarm_entry_t alarm_entry_o
);
    import fault_report_pkg::*;

    // Bytes in use for the chosen variant
    localparam int IN_BYTES = LARGE_UNIT ? LARGE_IN_BYTES : SMALL_IN_BYTES;
    localparam int OUT_BYTES = LARGE_UNIT ? LARGE_OUT_BYTES : SMALL_OUT_BYTES;

    logic [ADDR_W-1:0] in_off; // Offset into the input area
    logic [ADDR_W-1:0] out_off; // Offset into the output area
    logic [7:0] latch_q [MAX_OUT_BYTES]; // Output bytes last written by the link
    logic [7:0] latch_d [MAX_OUT_BYTES];
    logic [7:0] fault_q [MAX_OUT_BYTES]; // Per-point fault bits per output byte
    logic [7:0] fault_d [MAX_OUT_BYTES];
    logic [MAX_OUT_BYTES*8-1:0] dout_q; // Driven output points
    logic [MAX_OUT_BYTES*8-1:0] dout_d;
    logic [7:0] rd_q; // Input byte answer
    logic [7:0] rd_d;
    logic rd_hit_q;
    logic rd_hit_d;
    logic [MAX_OUT_BYTES-1:0] pend_q; // Bytes whose alarm data awaits reporting
    logic [MAX_OUT_BYTES-1:0] pend_d;
    logic valid_q; // An entry is offered
    logic valid_d;
    alarm_entry_t entry_q; // Entry being offered
    alarm_entry_t entry_d;

    // Offsets from the allocated start addresses
    assign in_off = in_rd_addr_i - input_area_base_i;
    assign out_off = out_wr_i.addr - output_area_base_i;
    assign out_wr_hit_o = out_wr_i.valid && (out_off < ADDR_W'(OUT_BYTES));

    // A driver fault never raises a unit or controller alarm
    assign unit_alarm_o = 1'b0;

    // Next state of output latches, fault bits and driven points
    always_comb begin
        for (int b = 0; b < MAX_OUT_BYTES; b++) begin
            latch_d[b] = latch_q[b];
            fault_d[b] = BYTE_RESET;
            dout_d[b*8 +: 8] = BYTE_RESET;
            if (b < OUT_BYTES) begin
                // Link write lands on the byte at its offset
                if (out_wr_hit_o && out_off[INFO_W-1:0] == INFO_W'(b)) begin
                    latch_d[b] = out_wr_i.data;
                end
                // Fault bits follow the detectors, clearing when gone
                fault_d[b] = point_fault_i[b*8 +: 8];
                // Tripped byte is held off; others pass unaffected
                if (byte_trip_i[b]) begin
                    dout_d[b*8 +: 8] = BYTE_RESET;
                end else begin
                    dout_d[b*8 +: 8] = latch_q[b];
                end
            end
        end
    end

    // Input byte read at its offset
    always_comb begin
        rd_d = BYTE_RESET;
        rd_hit_d = 1'b0;
        if (in_off < ADDR_W'(IN_BYTES)) begin
            rd_d = in_points_i[in_off[3:0]*8 +: 8];
            rd_hit_d = 1'b1;
        end
    end

    // Report queue: pend on change, offer lowest pending byte
    always_comb begin
        pend_d = pend_q;
        valid_d = valid_q;
        entry_d = entry_q;
        // Offered entry taken by the controller
        if (valid_q && alarm_ready_i) begin
            valid_d = 1'b0;
        end
        // Pick next byte when nothing is offered
        // Ascending scan: once one byte is picked the rest stay pending
        for (int b = 0; b < MAX_OUT_BYTES; b++) begin
            if (!valid_d && pend_q[b]) begin
                valid_d = 1'b1;
                pend_d[b] = 1'b0;
                entry_d.kind = ALARM_TYPE;
                entry_d.group = group_i;
                entry_d.path = path_i;
                entry_d.slot = ALARM_SLOT;
                entry_d.info = INFO_W'(b);
                entry_d.out_addr = output_area_base_i + ADDR_W'(b);
                entry_d.data = fault_q[b];
            end
        end
        // A change arriving in the pick cycle still pends: set wins
        for (int b = 0; b < OUT_BYTES; b++) begin
            if (fault_d[b] != fault_q[b]) begin
                pend_d[b] = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            for (int b = 0; b < MAX_OUT_BYTES; b++) begin
                latch_q[b] <= BYTE_RESET;
                fault_q[b] <= BYTE_RESET;
            end
            dout_q <= '0;
            rd_q <= BYTE_RESET;
            rd_hit_q <= 1'b0;
            pend_q <= PEND_RESET;
            valid_q <= 1'b0;
            entry_q <= '0;
        end else begin
            latch_q <= latch_d;
            fault_q <= fault_d;
            dout_q <= dout_d;
            rd_q <= rd_d;
            rd_hit_q <= rd_hit_d;
            pend_q <= pend_d;
            valid_q <= valid_d;
            entry_q <= entry_d;
        end
    end

    assign out_points_o = dout_q;
    assign in_rd_data_o = rd_q;
    assign in_rd_hit_o = rd_hit_q;
    assign alarm_valid_o = valid_q;
    assign alarm_entry_o = entry_q;

    // Per-byte checks of trip, pass-through, fault queueing and alarm data
    for (genvar g = 0; g < OUT_BYTES; g++) begin : g_byte_chk
        // Protection seen at one edge leaves the byte dark after it
        property p_trip_off;
            @(posedge mclk_i) disable iff (reset_i)
            byte_trip_i[g] |=> out_points_o[g*8 +: 8] == 8'h00;
        endproperty
        a_trip_off: assert property (p_trip_off) else $error("tripped byte not forced off");

        // Untripped byte follows its latch one edge later
        property p_pass;
            @(posedge mclk_i) disable iff (reset_i)
            !byte_trip_i[g] |=> out_points_o[g*8 +: 8] == $past(latch_q[g]);
        endproperty
        a_pass: assert property (p_pass) else $error("healthy byte not driven from latch");

        // Any change of a byte's fault bits is queued or already offered
        property p_pend;
            @(posedge mclk_i) disable iff (reset_i)
            (point_fault_i[g*8 +: 8] != fault_q[g]) |=> pend_q[g] || (valid_q && entry_q.info == g);
        endproperty
        a_pend: assert property (p_pend) else $error("fault change not queued for report");

        // Cleared detectors give clear bits and a driven byte at the next edge
        property p_clear;
            @(posedge mclk_i) disable iff (reset_i)
            (point_fault_i[g*8 +: 8] == 8'h00) && !byte_trip_i[g] |=>
                fault_q[g] == 8'h00 && out_points_o[g*8 +: 8] == $past(latch_q[g]);
        endproperty
        a_clear: assert property (p_clear) else $error("recovered byte not released");

        // Lowest pending byte is offered next, carrying its fault bits
        property p_data;
            @(posedge mclk_i) disable iff (reset_i)
            (!valid_q || alarm_ready_i) && pend_q[g] && (pend_q & MAX_OUT_BYTES'((1 << g) - 1)) == '0 |=>
                alarm_valid_o && alarm_entry_o.info == g && alarm_entry_o.data == $past(fault_q[g]);
        endproperty
        a_data: assert property (p_data) else $error("alarm data differs from fault bits");
    end

    // Fixed fields of every offered entry
    property p_fields;
        @(posedge mclk_i) disable iff (reset_i)
        alarm_valid_o |-> alarm_entry_o.kind == 4'h0 && alarm_entry_o.slot == 4'h1
            && alarm_entry_o.info < OUT_BYTES;
    endproperty
    a_fields: assert property (p_fields) else $error("alarm entry fixed fields wrong");

    // Placement fields follow the unit's group and output base
    property p_place;
        @(posedge mclk_i) disable iff (reset_i)
        $rose(alarm_valid_o) |-> alarm_entry_o.group == $past(group_i)
            && alarm_entry_o.out_addr == $past(output_area_base_i) + ADDR_W'(alarm_entry_o.info);
    endproperty
    a_place: assert property (p_place) else $error("group or output address wrong");
endmodule

`default_nettype wire

//--- dv/ladder_controller_model.sv
`timescale 1ns/100ps
`default_nettype none

// Controller end of the alarm handshake, prompt or stalling
module ladder_controller_model (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic slow_i,
    input wire logic alarm_valid_i,
    input wire fault_report_pkg::alarm_entry_t alarm_entry_i,
    output logic alarm_ready_o,
    output logic took_o,
    output fault_report_pkg::alarm_entry_t got_o
);
    import fault_report_pkg::*;
    logic [1:0] wait_q; // Cycles stalled on the current offer
    // Ready at once, or only after three stalled cycles when slow
    always_comb alarm_ready_o = alarm_valid_i && (!slow_i || wait_q == 2'h3);
    // Entry lands in the relay area at the edge where ready is high
    always_ff @(posedge mclk_i) begin
        took_o <= 1'b0;
        if (reset_i) begin
            wait_q <= 2'h0;
        end else if (alarm_ready_o) begin
            wait_q <= 2'h0;
            took_o <= 1'b1;
            got_o <= alarm_entry_i;
        end else if (alarm_valid_i) begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import fault_report_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [ADDR_W-1:0] in_base = 16'h0100; // Input area start
    logic [ADDR_W-1:0] out_base = 16'h0200; // Output area start
    logic [GROUP_W-1:0] group = 5'h17;
    logic [PATH_W-1:0] path = 4'h9;
    logic [MAX_IN_BYTES*8-1:0] in_pins = '0;
    logic [ADDR_W-1:0] rd_addr = 16'h0000;
    out_write_t wr = '0;
    logic [MAX_OUT_BYTES-1:0] trip = 8'h00;
    logic [MAX_OUT_BYTES*8-1:0] faults = 64'h0;
    logic slow = 1'b0;
    logic ready0;
    logic took;
    alarm_entry_t got;
    logic [7:0] rd_data [2];
    logic [63:0] outs [2];
    alarm_entry_t entry [2];
    logic [1:0] rd_hit, wr_hit, unit_alarm, a_valid;
    int bad_count = 0;
    int checks = 0;

    // Free-running clock
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    // Unit 0 is the large variant, unit 1 the small one
    for (genvar v = 0; v < 2; v++) begin : g_unit
        output_fault_status_reporting #(.LARGE_UNIT(v == 0)) u_dut (
            .mclk_i(mclk_i), .reset_i(reset_i), .input_area_base_i(in_base), .output_area_base_i(out_base),
            .group_i(group), .path_i(path), .in_points_i(in_pins), .in_rd_addr_i(rd_addr),
            .in_rd_data_o(rd_data[v]), .in_rd_hit_o(rd_hit[v]), .out_wr_i(wr), .out_wr_hit_o(wr_hit[v]),
            .byte_trip_i(trip), .point_fault_i(faults), .out_points_o(outs[v]), .unit_alarm_o(unit_alarm[v]),
            .alarm_valid_o(a_valid[v]), .alarm_ready_i((v == 0) ? ready0 : 1'b1), .alarm_entry_o(entry[v]));
    end

    ladder_controller_model u_ctrl (.mclk_i(mclk_i), .reset_i(reset_i), .slow_i(slow), .alarm_valid_i(a_valid[0]),
        .alarm_entry_i(entry[0]), .alarm_ready_o(ready0), .took_o(took), .got_o(got));

    task automatic chk(input logic [63:0] got_v, input logic [63:0] exp_v);
        checks++;
        if (got_v !== exp_v) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One output byte write, returning both units' hit flags
    task automatic wr_byte(input logic [15:0] off, input logic [7:0] d, output logic [1:0] h);
        @(posedge mclk_i);
        wr <= '{1'b1, out_base + off, d};
        #1;
        h = wr_hit;
        @(posedge mclk_i);
        wr.valid <= 1'b0;
    endtask

    // Every output offset plus the first one past the large area
    task automatic t_write();
        logic [1:0] h;
        for (int off = 0; off < 9; off++) begin
            wr_byte(16'(off), 8'hA0 + 8'(off), h);
            chk(64'(h), {62'h0, off < 4, off < 8});
        end
        repeat (2) @(posedge mclk_i);
        #1;
        chk(outs[0], 64'hA7A6A5A4A3A2A1A0);
        chk(outs[1], 64'h00000000A3A2A1A0);
    endtask

    // Every input offset plus the first one past the large area
    task automatic t_read();
        for (int off = 0; off < 13; off++) begin
            @(posedge mclk_i);
            rd_addr <= in_base + 16'(off);
            @(posedge mclk_i);
            #1;
            chk({rd_hit, rd_data[0]}, {off < 8, off < 12, off < 12 ? 8'h30 + 8'(off) : 8'h00});
            chk(64'(rd_data[1]), {56'h0, off < 8 ? 8'h30 + 8'(off) : 8'h00});
        end
    endtask

    // Byte 2 tripped while byte 5 keeps taking writes
    task automatic t_trip();
        logic [1:0] h;
        @(posedge mclk_i);
        trip <= 8'h04;
        wr_byte(16'h0005, 8'h55, h);
        repeat (2) @(posedge mclk_i);
        #1;
        chk(outs[0], 64'hA7A655A4A300A1A0);
        chk(64'(unit_alarm), 64'h0);
        @(posedge mclk_i);
        trip <= 8'h00;
        repeat (2) @(posedge mclk_i);
        #1;
        chk(outs[0], 64'hA7A655A4A3A2A1A0);
    endtask

    // Change one byte's fault bits and judge the entry taken
    task automatic t_alarm(input logic s, input logic [2:0] b, input logic [7:0] bits);
        alarm_entry_t e1;
        alarm_entry_t want;
        e1 = '0;
        want = '{ALARM_TYPE, group, path, ALARM_SLOT, b, out_base + 16'(b), bits};
        @(posedge mclk_i);
        slow <= s;
        faults[{b, 3'h0} +: 8] <= bits;
        repeat (20) begin
            @(posedge mclk_i);
            // Small unit takes at once; catch its one-cycle offer
            if (a_valid[1] === 1'b1) begin
                e1 = entry[1];
            end
            if (took === 1'b1) break;
        end
        chk({took, got}, {1'b1, ALARM_TYPE, group, path, ALARM_SLOT, b, out_base + 16'(b), bits});
        chk(64'(e1), b < 3'h4 ? 64'(want) : 64'h0);
    endtask

    // Hang guard
    initial begin
        repeat (3000) @(posedge mclk_i);
        bad_count++;
        stop_test();
    end

    initial begin
        for (int b = 0; b < MAX_IN_BYTES; b++) begin
            in_pins[b*8 +: 8] = 8'h30 + 8'(b);
        end
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_write();
        t_read();
        t_trip();
        t_alarm(1'b0, 3'h3, 8'h81);
        t_alarm(1'b1, 3'h7, 8'hFF);
        t_alarm(1'b0, 3'h3, 8'h00);
        stop_test();
    end
endmodule

`default_nettype wire
